// File: src/sfcd_top.sv
`timescale 1ns/1ps
`include "sfcd_cfg.svh"
// Function
// R1: quad entry code switches to four lines
// R2: quad exit code returns to single line
// R3: four-line mode uses all four lanes
// R4: dual read single-line only, dummy default four
// R5: fixed-wait quad read, always four dummies
// R6: dummy count from configuration bits six, seven
// R7: fast read both modes, default eight dummies
// R8: half block erase, three address bytes
// R9: shared code wakes; signature after 24 dummies
// R10: sleep entry code, no address or data
// R11: id read single-line; address picks order
// R12: factory state read returns one byte
// R13: host arms before issuing soft reset
// R14: reset ignored unless arm was last
// R15: host avoids undefined codes and addresses
// R16: two pause codes, both modes accepted
// R17: two continue codes, both modes accepted
// R18: command byte eight or two clocks
// R19: non-read needs select high on boundary
// R20: sample on rising, shift on falling
// R21: write permit latch gates erase commands
// R22: quad mode ignores single-line-only codes
// R23: msb first, one lookup per code
// R24: rejected command leaves outputs floating
module sfcd_top
  import sfcd_pkg::*;
#(
  parameter logic [7:0] SIG_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] MAKER_ID = 8'ha5, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h3c // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] sio_in,
  output logic [3:0] sio_out,
  output logic [3:0] sio_oe,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] config_byte,
  input wire logic [7:0] factory_byte,
  input wire logic [7:0] array_byte,
  output logic quad_mode,
  output logic write_permit_latch,
  output logic erase_start,
  output logic [1:0] erase_size,
  output logic [23:0] erase_addr,
  output logic job_pause,
  output logic job_continue,
  output logic sleep_enter,
  output logic sleep_release,
  output logic soft_reset,
  output logic cmd_reject
);

  function automatic logic [2:0] sfcd_lanes(input logic q);
    return q ? 3'h4 : 3'h1; // [R3]
  endfunction

  // clocks needed to move a number of bits over w lanes
  function automatic logic [4:0] sfcd_cyc(input logic [2:0] w, input logic [4:0] nbits);
    case (w)
      3'h4: return nbits >> 2;
      3'h2: return nbits >> 1;
      default: return nbits;
    endcase
  endfunction

  function automatic logic [4:0] sfcd_dmy(input logic [4:0] dflt, input logic [1:0] sel);
    case (sel) // [R6]
      2'h1: return `SFCD_DMY_SEL1;
      2'h2: return `SFCD_DMY_SEL2;
      2'h3: return `SFCD_DMY_SEL3;
      default: return dflt;
    endcase
  endfunction

  // msb arrives first, highest lane carries the higher bit
  function automatic logic [23:0] sfcd_take(input logic [23:0] v, input logic [3:0] s,
                                            input logic [2:0] w);
    case (w) // [R23]
      3'h4: return {v[19:0], s};
      3'h2: return {v[21:0], s[1:0]};
      default: return {v[22:0], s[0]};
    endcase
  endfunction

  function automatic logic [3:0] sfcd_put(input logic [7:0] b, input logic [2:0] w);
    case (w)
      3'h4: return b[7:4];
      3'h2: return {2'h0, b[7:6]};
      default: return {2'h0, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] sfcd_mask(input logic [2:0] w);
    case (w)
      3'h4: return 4'hf;
      3'h2: return 4'h3;
      default: return 4'h2;
    endcase
  endfunction

  // framing of every code from one table
  function automatic sfcd_dec_t sfcd_lookup(input logic [7:0] op, input logic q,
                                            input logic [1:0] sel);
    sfcd_dec_t d;
    logic [2:0] mw;
    mw = sfcd_lanes(q);
    d = '{known: 1'b1, aw: mw, acyc: 5'h00, dcyc: 5'h00, dw: mw, src: SRC_NONE, one: 1'b0};
    case (op) // [R23]
      `SFCD_OP_READ: begin
        d.known = !q; // [R22]
        d.acyc = 5'h18;
        d.src = SRC_ARRAY;
      end
      `SFCD_OP_FAST: begin
        d.acyc = sfcd_cyc(mw, 5'h18); // [R7]
        d.dcyc = sfcd_dmy(`SFCD_DMY_FAST, sel);
        d.src = SRC_ARRAY;
      end
      `SFCD_OP_DUAL: begin
        d.known = !q; // [R4] [R22]
        d.aw = 3'h2;
        d.acyc = 5'h0c;
        d.dcyc = sfcd_dmy(`SFCD_DMY_DUAL, sel);
        d.dw = 3'h2;
        d.src = SRC_ARRAY;
      end
      `SFCD_OP_DOUT, `SFCD_OP_QOUT: begin
        d.known = !q; // [R22]
        d.acyc = 5'h18;
        d.dcyc = sfcd_dmy(`SFCD_DMY_FAST, sel);
        d.dw = (op == `SFCD_OP_DOUT) ? 3'h2 : 3'h4;
        d.src = SRC_ARRAY;
      end
      `SFCD_OP_QFIX: begin
        d.known = !q; // [R5] [R22]
        d.aw = 3'h4;
        d.acyc = 5'h06;
        d.dcyc = `SFCD_DMY_QFIX;
        d.dw = 3'h4;
        d.src = SRC_ARRAY;
      end
      `SFCD_OP_QIO: begin
        d.aw = 3'h4;
        d.acyc = 5'h06;
        d.dcyc = sfcd_dmy(`SFCD_DMY_QIO, sel);
        d.dw = 3'h4;
        d.src = SRC_ARRAY;
      end
      `SFCD_OP_SE, `SFCD_OP_HBE, `SFCD_OP_BE: begin
        d.acyc = sfcd_cyc(mw, 5'h18); // [R8]
      end
      `SFCD_OP_WAKE: begin
        d.dcyc = `SFCD_DMY_SIG; // [R9]
        d.src = SRC_SIG;
      end
      `SFCD_OP_IDRD: begin
        d.known = !q; // [R11] [R22]
        d.acyc = 5'h18;
        d.src = SRC_ID;
      end
      `SFCD_OP_FSTAT: begin
        d.src = SRC_FACT; // [R12]
        d.one = 1'b1;
      end
      `SFCD_OP_RDST: d.src = SRC_STAT;
      `SFCD_OP_RDCF: d.src = SRC_CFG;
      `SFCD_OP_QEN: d.known = !q; // [R1]
      `SFCD_OP_QEX: d.known = q; // [R2]
      `SFCD_OP_PAUSE_A, `SFCD_OP_PAUSE_B: d.known = 1'b1; // [R16]
      `SFCD_OP_CONT_A, `SFCD_OP_CONT_B: d.known = 1'b1; // [R17]
      `SFCD_OP_SLEEP: d.known = 1'b1; // [R10]
      `SFCD_OP_WRITE_PERMIT_CMD, `SFCD_OP_WRDI, `SFCD_OP_CE_A, `SFCD_OP_CE_B: d.known = 1'b1;
      `SFCD_OP_ARM, `SFCD_OP_RST, `SFCD_OP_NOP: d.known = 1'b1;
      default: d.known = 1'b0; // [R15]
    endcase
    return d;
  endfunction

  function automatic sfcd_phase_t sfcd_after(input sfcd_dec_t d, input sfcd_phase_t from);
    if (!d.known) return PH_HOLD; // [R24]
    if (from == PH_CMD && d.acyc != 5'h00) return PH_ADDR;
    if (from != PH_DUMMY && d.dcyc != 5'h00) return PH_DUMMY;
    if (d.src != SRC_NONE) return PH_DATA;
    return PH_HOLD;
  endfunction

  logic frame_rst_n;
  sfcd_phase_t ph_q;
  sfcd_phase_t ph_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] ph_last;
  logic [2:0] bits_q;
  logic [2:0] bits_d;
  logic [2:0] w_mode;
  logic [2:0] w_in;
  logic first_q;
  sfcd_dec_t dec_q;
  sfcd_dec_t dec_new;
  sfcd_dec_t dec_cur;
  logic mode_q;
  logic mode_eff;
  logic commit_en;
  logic [7:0] cmd_sr_q;
  logic [7:0] cmd_next;
  logic [7:0] code_q;
  logic [23:0] take_cmd;
  logic [23:0] addr_q;
  logic seen_q;
  logic cmpl_q;
  logic aligned_q;
  logic rd_q;
  logic [1:0] dc_s1_q;
  logic [1:0] dc_s2_q;
  logic [1:0] dc_s3_q;
  logic [1:0] dc_f_q;
  logic [7:0] src_byte;
  logic [7:0] cur_byte;
  logic [7:0] osr_q;
  logic [2:0] ocnt_q;
  logic [2:0] olast;
  logic swap_q;
  logic [3:0] sio_out_q;
  logic [3:0] sio_oe_q;

  // raising chip select clears the frame state; link clock may stop between frames
  assign frame_rst_n = rst_n & ~cs_n;

  // mode change commits on the first edge of the next frame, once the last frame
  // proved to be a whole, byte-aligned mode command
  always_comb begin
    commit_en = first_q & seen_q & cmpl_q & aligned_q & ~rd_q; // [R19]
    mode_eff = mode_q;
    if (commit_en && code_q == `SFCD_OP_QEN) mode_eff = 1'b1; // [R1]
    if (commit_en && code_q == `SFCD_OP_QEX) mode_eff = 1'b0; // [R2]
  end

  always_comb begin
    w_mode = sfcd_lanes(mode_eff); // [R3]
    take_cmd = sfcd_take({16'h0000, cmd_sr_q}, sio_in, w_mode);
    cmd_next = take_cmd[7:0];
    dec_new = sfcd_lookup(cmd_next, mode_eff, dc_f_q);
    dec_cur = (ph_q == PH_CMD) ? dec_new : dec_q;
  end

  always_comb begin
    ph_d = ph_q;
    cnt_d = cnt_q + 5'h01;
    w_in = w_mode;
    ph_last = 5'h00;
    case (ph_q)
      PH_CMD: begin
        ph_last = sfcd_cyc(w_mode, 5'h08) - 5'h01; // [R18]
        if (cnt_q == ph_last) ph_d = sfcd_after(dec_new, PH_CMD);
      end
      PH_ADDR: begin
        w_in = dec_q.aw;
        ph_last = dec_q.acyc - 5'h01;
        if (cnt_q == ph_last) ph_d = sfcd_after(dec_q, PH_ADDR);
      end
      PH_DUMMY: begin
        ph_last = dec_q.dcyc - 5'h01; // [R4] [R5] [R6] [R7] [R9]
        if (cnt_q == ph_last) ph_d = sfcd_after(dec_q, PH_DUMMY);
      end
      PH_DATA: begin
        ph_last = sfcd_cyc(dec_q.dw, 5'h08) - 5'h01;
        if (dec_q.one && cnt_q == ph_last) ph_d = PH_HOLD; // [R12]
      end
      PH_HOLD: ph_d = PH_HOLD; // [R24]
      default: ph_d = PH_HOLD;
    endcase
    if (ph_d != ph_q) cnt_d = 5'h00;
    bits_d = bits_q + w_in; // [R19]
  end

  // input lanes are taken on the rising link edge
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      ph_q <= PH_CMD;
      cnt_q <= 5'h00;
      bits_q <= 3'h0;
      first_q <= 1'b1;
    end else begin
      ph_q <= ph_d; // [R20]
      cnt_q <= cnt_d;
      bits_q <= bits_d;
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      dec_q <= '0;
      cmd_sr_q <= 8'h00;
    end else if (ph_q == PH_CMD) begin
      cmd_sr_q <= cmd_next; // [R23]
      if (ph_d != PH_CMD) dec_q <= dec_new;
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) mode_q <= 1'b0;
    else mode_q <= mode_eff; // [R1] [R2]
  end

  // frame record survives chip select high for the system side to read
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      code_q <= 8'h00;
      addr_q <= 24'h000000;
      seen_q <= 1'b0;
      cmpl_q <= 1'b0;
      aligned_q <= 1'b1;
      rd_q <= 1'b0;
    end else begin
      aligned_q <= bits_d == 3'h0; // [R19]
      if (first_q) begin
        seen_q <= 1'b0;
        cmpl_q <= 1'b0;
      end
      if (ph_q == PH_CMD && ph_d != PH_CMD) begin
        code_q <= cmd_next;
        seen_q <= 1'b1;
        rd_q <= dec_new.known && dec_new.src != SRC_NONE; // [R24]
      end
      if (ph_q != PH_DATA && ph_q != PH_HOLD && (ph_d == PH_DATA || ph_d == PH_HOLD))
        cmpl_q <= dec_cur.known;
      if (ph_q == PH_ADDR) addr_q <= sfcd_take(addr_q, sio_in, dec_q.aw); // [R8] [R11]
    end
  end

  // wait-cycle select crosses into the link domain
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      dc_s1_q <= 2'h0;
      dc_s2_q <= 2'h0;
      dc_s3_q <= 2'h0;
      dc_f_q <= 2'h0;
    end else begin
      dc_s1_q <= {config_byte[`SFCD_DC_HI], config_byte[`SFCD_DC_LO]}; // [R6]
      dc_s2_q <= dc_s1_q;
      dc_s3_q <= dc_s2_q;
      if (dc_s2_q == dc_s3_q) dc_f_q <= dc_s3_q;
    end
  end

  always_comb begin
    case (dec_q.src)
      SRC_ARRAY: src_byte = array_byte;
      SRC_STAT: src_byte = status_byte;
      SRC_CFG: src_byte = config_byte;
      SRC_FACT: src_byte = factory_byte;
      SRC_SIG: src_byte = SIG_ID; // [R9]
      SRC_ID: src_byte = (swap_q ^ (addr_q[7:0] == `SFCD_ID_PART_FIRST)) ? PART_ID
                                                                            : MAKER_ID; // [R11]
      default: src_byte = 8'h00;
    endcase
    cur_byte = (ocnt_q == 3'h0) ? src_byte : osr_q;
    olast = 3'(sfcd_cyc(dec_q.dw, 5'h08) - 5'h01);
  end

  // output bits move on the falling link edge, msb first
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      osr_q <= 8'h00;
      ocnt_q <= 3'h0;
      swap_q <= 1'b0;
    end else if (ph_q == PH_DATA) begin
      osr_q <= cur_byte << dec_q.dw; // [R20] [R23]
      ocnt_q <= (ocnt_q == olast) ? 3'h0 : ocnt_q + 3'h1;
      if (ocnt_q == olast) swap_q <= ~swap_q;
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sio_out_q <= 4'h0;
      sio_oe_q <= 4'h0;
    end else if (ph_q == PH_DATA) begin
      sio_out_q <= sfcd_put(cur_byte, dec_q.dw); // [R3] [R20]
      sio_oe_q <= sfcd_mask(dec_q.dw);
    end else begin
      sio_out_q <= 4'h0;
      sio_oe_q <= 4'h0; // [R24]
    end
  end

  assign sio_out = sio_out_q;
  assign sio_oe = sio_oe_q;

  sfcd_frame_if fr ();

  assign fr.code = code_q;
  assign fr.addr = addr_q;
  assign fr.seen = seen_q;
  assign fr.cmpl = cmpl_q;
  assign fr.aligned = aligned_q;
  assign fr.rd = rd_q;
  assign fr.quad = mode_q;

  sfcd_exec u_exec (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .fr(fr),
    .quad_mode(quad_mode),
    .write_permit_latch(write_permit_latch),
    .erase_start(erase_start),
    .erase_size(erase_size),
    .erase_addr(erase_addr),
    .job_pause(job_pause),
    .job_continue(job_continue),
    .sleep_enter(sleep_enter),
    .sleep_release(sleep_release),
    .soft_reset(soft_reset),
    .cmd_reject(cmd_reject)
  );

endmodule

// File: shared/sfcd_cfg.svh
`ifndef SFCD_CFG_SVH
`define SFCD_CFG_SVH

// command codes
`define SFCD_OP_READ 8'h03
`define SFCD_OP_FAST 8'h0b
`define SFCD_OP_DUAL 8'hbb
`define SFCD_OP_DOUT 8'h3b
`define SFCD_OP_QFIX 8'he7
`define SFCD_OP_QIO 8'heb
`define SFCD_OP_QOUT 8'h6b
`define SFCD_OP_SE 8'h20
`define SFCD_OP_HBE 8'h52
`define SFCD_OP_BE 8'hd8
`define SFCD_OP_CE_A 8'h60
`define SFCD_OP_CE_B 8'hc7
`define SFCD_OP_WRITE_PERMIT_CMD 8'h06
`define SFCD_OP_WRDI 8'h04
`define SFCD_OP_QEN 8'h35
`define SFCD_OP_QEX 8'hf5
`define SFCD_OP_PAUSE_A 8'h75
`define SFCD_OP_PAUSE_B 8'hb0
`define SFCD_OP_CONT_A 8'h7a
`define SFCD_OP_CONT_B 8'h30
`define SFCD_OP_SLEEP 8'hb9
`define SFCD_OP_WAKE 8'hab
`define SFCD_OP_IDRD 8'h90
`define SFCD_OP_FSTAT 8'h44
`define SFCD_OP_RDST 8'h05
`define SFCD_OP_RDCF 8'h15
`define SFCD_OP_ARM 8'h66
`define SFCD_OP_RST 8'h99
`define SFCD_OP_NOP 8'h00

// configuration byte fields
`define SFCD_DC_LO 6
`define SFCD_DC_HI 7

// dummy cycle counts
`define SFCD_DMY_FAST 5'h08
`define SFCD_DMY_DUAL 5'h04
`define SFCD_DMY_QFIX 5'h04
`define SFCD_DMY_QIO 5'h06
`define SFCD_DMY_SIG 5'h18
`define SFCD_DMY_SEL1 5'h06
`define SFCD_DMY_SEL2 5'h08
`define SFCD_DMY_SEL3 5'h0a

// id read address selecting part code first
`define SFCD_ID_PART_FIRST 8'h01

// erase size codes
`define SFCD_ERS_SECTOR 2'h0
`define SFCD_ERS_HALF 2'h1
`define SFCD_ERS_BLOCK 2'h2
`define SFCD_ERS_CHIP 2'h3

`endif

// File: shared/sfcd_pkg.sv
package sfcd_pkg;

  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_HOLD} sfcd_phase_t;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_ARRAY, SRC_STAT, SRC_CFG, SRC_FACT, SRC_SIG, SRC_ID
  } sfcd_src_t;

  typedef struct packed {
    logic known;
    logic [2:0] aw;
    logic [4:0] acyc;
    logic [4:0] dcyc;
    logic [2:0] dw;
    sfcd_src_t src;
    logic one;
  } sfcd_dec_t;

endpackage

// File: shared/sfcd_if.sv
`timescale 1ns/1ps
interface sfcd_frame_if;
  logic [7:0] code;
  logic [23:0] addr;
  logic seen;
  logic cmpl;
  logic aligned;
  logic rd;
  logic quad;
  modport link (output code, addr, seen, cmpl, aligned, rd, quad);
  modport exec (input code, addr, seen, cmpl, aligned, rd, quad);
endinterface

// File: src/sfcd_exec.sv
`timescale 1ns/1ps
`include "sfcd_cfg.svh"
module sfcd_exec
  import sfcd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  sfcd_frame_if.exec fr,
  output logic quad_mode,
  output logic write_permit_latch,
  output logic erase_start,
  output logic [1:0] erase_size,
  output logic [23:0] erase_addr,
  output logic job_pause,
  output logic job_continue,
  output logic sleep_enter,
  output logic sleep_release,
  output logic soft_reset,
  output logic cmd_reject
);
  logic [2:0] cs_s_q;
  logic cs_f_q;
  logic [2:0] qd_s_q;
  logic qd_f_q;
  logic end_evt;
  logic ok;
  logic is_erase;
  logic wel_q;
  logic arm_q;

  // chip select and mode level crossings, first stage feeds second only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s_q <= 3'h7;
      cs_f_q <= 1'b1;
      qd_s_q <= 3'h0;
      qd_f_q <= 1'b0;
    end else begin
      cs_s_q <= {cs_s_q[1:0], cs_n};
      qd_s_q <= {qd_s_q[1:0], fr.quad};
      if (cs_s_q[1] == cs_s_q[2]) cs_f_q <= cs_s_q[2];
      if (qd_s_q[1] == qd_s_q[2]) qd_f_q <= qd_s_q[2];
    end
  end

  // frame record is frozen while chip select is high
  assign end_evt = !cs_f_q && cs_s_q[1] && cs_s_q[2];
  assign ok = fr.seen && fr.cmpl && fr.aligned; // [R19]
  assign is_erase = fr.code == `SFCD_OP_SE || fr.code == `SFCD_OP_HBE ||
                    fr.code == `SFCD_OP_BE || fr.code == `SFCD_OP_CE_A ||
                    fr.code == `SFCD_OP_CE_B;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_q <= 1'b0;
    end else if (end_evt && ok) begin
      if (fr.code == `SFCD_OP_WRITE_PERMIT_CMD) wel_q <= 1'b1; // [R21]
      else if (fr.code == `SFCD_OP_WRDI || is_erase) wel_q <= 1'b0;
      else if (fr.code == `SFCD_OP_PAUSE_A || fr.code == `SFCD_OP_PAUSE_B) wel_q <= 1'b0;
      else if (fr.code == `SFCD_OP_RST && arm_q) wel_q <= 1'b0;
    end
  end

  // any whole command byte other than the arm code disarms
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) arm_q <= 1'b0;
    else if (end_evt && fr.seen) arm_q <= ok && fr.code == `SFCD_OP_ARM; // [R13] [R14]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_start <= 1'b0;
      erase_size <= `SFCD_ERS_SECTOR;
      erase_addr <= 24'h000000;
      job_pause <= 1'b0;
      job_continue <= 1'b0;
      sleep_enter <= 1'b0;
      sleep_release <= 1'b0;
      soft_reset <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      erase_start <= end_evt && ok && is_erase && wel_q; // [R8] [R21]
      job_pause <= end_evt && ok &&
                   (fr.code == `SFCD_OP_PAUSE_A || fr.code == `SFCD_OP_PAUSE_B); // [R16]
      job_continue <= end_evt && ok &&
                      (fr.code == `SFCD_OP_CONT_A || fr.code == `SFCD_OP_CONT_B); // [R17]
      sleep_enter <= end_evt && ok && fr.code == `SFCD_OP_SLEEP; // [R10]
      sleep_release <= end_evt && fr.seen && fr.code == `SFCD_OP_WAKE; // [R9]
      soft_reset <= end_evt && ok && fr.code == `SFCD_OP_RST && arm_q; // [R14]
      cmd_reject <= end_evt && fr.seen && !fr.rd && (!ok || (is_erase && !wel_q)); // [R19]
      if (end_evt && ok && is_erase && wel_q) begin
        erase_addr <= fr.addr;
        case (fr.code)
          `SFCD_OP_SE: erase_size <= `SFCD_ERS_SECTOR;
          `SFCD_OP_HBE: erase_size <= `SFCD_ERS_HALF;
          `SFCD_OP_BE: erase_size <= `SFCD_ERS_BLOCK;
          default: erase_size <= `SFCD_ERS_CHIP;
        endcase
      end
    end
  end

  assign quad_mode = qd_f_q;
  assign write_permit_latch = wel_q;
endmodule

// File: verif/sfcd_host.sv
`timescale 1ns/1ps
module sfcd_host (
  input wire logic sys_clk,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] sio_in,
  input wire logic [3:0] sio_out
);
  logic [15:0] rd_data;
  event rd_ev;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sio_in = 4'h5;
    rd_data = 16'h0;
  end
  // drive after the fall, sample on the rise
  task automatic tick(input logic [3:0] v, input bit q);
    sio_in = v;
    #62.5 sclk = 1'b1;
    rd_data = q ? {rd_data[11:0], sio_out} : {rd_data[14:0], sio_out[1]};
    #62.5 sclk = 1'b0;
  endtask
  // msb first; spare lanes toggle in single-line mode
  task automatic send(input logic [23:0] v, input int n, input bit q);
    for (int i = 0; i < (q ? n / 4 : n); i++) begin
      tick(q ? v[23:20] : {~sio_in[3:1], v[23]}, q);
      v = q ? v << 4 : v << 1;
    end
  endtask
  // ends on a whole byte unless the caller asks for a short frame
  task automatic frame(input logic [7:0] op, input bit qc, input logic [23:0] ad,
      input int na, input bit qa, input int nd, input int nr);
    @(posedge sys_clk);
    #1 cs_n = 1'b0;
    #30;
    send({op, 16'h0}, 8, qc);
    send(ad, na, qa);
    repeat (nd) tick(~sio_in, qa);
    rd_data = 16'h0;
    repeat (nr * (qa ? 2 : 8)) tick(~sio_in, qa);
    #30 cs_n = 1'b1;
    sio_in = ~sio_in;
    if (nr > 0) -> rd_ev;
    #60;
  endtask
endmodule

// File: verif/sfcd_top_checker.sv
`timescale 1ns/1ps
module sfcd_top_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic [3:0] sio_oe,
  input wire logic quad_mode,
  input wire logic write_permit_latch,
  input wire logic erase_start,
  input wire logic [1:0] erase_size,
  input wire logic [23:0] erase_addr,
  input wire logic job_pause,
  input wire logic job_continue,
  input wire logic sleep_enter,
  input wire logic sleep_release,
  input wire logic soft_reset,
  input wire logic cmd_reject
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_erase_needs_latch: assert property (erase_start |-> $past(write_permit_latch))
    else $error("erase started without write permit");
  chk_latch_clears: assert property ((erase_start || soft_reset) |=> !write_permit_latch)
    else $error("write permit not cleared");
  chk_pulse_after_end: assert property ((erase_start || job_pause || job_continue ||
      sleep_enter || sleep_release || soft_reset || cmd_reject) |-> cs_n && $past(cs_n, 2))
    else $error("command acted before frame end");
  chk_oe_idle: assert property (cs_n |-> sio_oe == 4'h0)
    else $error("lanes driven while deselected");
  chk_quad_lanes: assert property (quad_mode && sio_oe != 4'h0 |-> sio_oe == 4'hf)
    else $error("quad mode output not on four lanes");
  chk_mode_at_rest: assert property ($changed(quad_mode) |-> !cs_n)
    else $error("mode changed outside a frame");
  chk_erase_fields: assert property ($changed(erase_addr) || $changed(erase_size) |-> erase_start)
    else $error("erase fields moved without erase");
  chk_reject_alone: assert property (cmd_reject |-> !(erase_start || soft_reset || job_pause ||
      job_continue || sleep_enter))
    else $error("rejected command still acted");
endmodule
bind sfcd_top sfcd_top_checker sfcd_top_checker_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .cs_n(cs_n), .sio_oe(sio_oe), .quad_mode(quad_mode), .write_permit_latch(write_permit_latch),
  .erase_start(erase_start), .erase_size(erase_size), .erase_addr(erase_addr),
  .job_pause(job_pause), .job_continue(job_continue), .sleep_enter(sleep_enter),
  .sleep_release(sleep_release), .soft_reset(soft_reset), .cmd_reject(cmd_reject));

// File: verif/serial_flash_command_decoder_tb.sv
`timescale 1ns/1ps
`include "sfcd_cfg.svh"
module serial_flash_command_decoder_tb;
  import sfcd_pkg::*;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end
  localparam logic [7:0] SG = 8'h4d; // arbitrary value
  localparam logic [7:0] MK = 8'h6e; // arbitrary value
  localparam logic [7:0] PT = 8'h71; // arbitrary value
  logic sys_clk, rst_n, sclk, cs_n, quad_mode, write_permit_latch, erase_start, job_pause;
  logic job_continue, sleep_enter, sleep_release, soft_reset, cmd_reject;
  logic [3:0] sio_in, sio_out, sio_oe;
  logic [7:0] status_byte, config_byte, factory_byte, array_byte;
  logic [1:0] erase_size;
  logic [23:0] erase_addr, ad;
  logic [39:0] exq[$];
  logic [7:0] ops[5] = '{8'hb9, 8'h75, 8'hb0, 8'h7a, 8'h30};
  logic [6:0] pls[5] = '{7'h08, 7'h20, 7'h20, 7'h10, 7'h10};
  int fails = 0, num_checks = 0, seed = 16898;
  int dmy[4] = '{8, 6, 8, 10};
  wire [6:0] pv = {erase_start, job_pause, job_continue, sleep_enter, sleep_release,
    soft_reset, cmd_reject};
  sfcd_top #(.SIG_ID(SG), .MAKER_ID(MK), .PART_ID(PT)) sfcd_top_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sio_in(sio_in), .sio_out(sio_out),
    .sio_oe(sio_oe), .status_byte(status_byte), .config_byte(config_byte),
    .factory_byte(factory_byte), .array_byte(array_byte), .quad_mode(quad_mode),
    .write_permit_latch(write_permit_latch), .erase_start(erase_start),
    .erase_size(erase_size), .erase_addr(erase_addr), .job_pause(job_pause),
    .job_continue(job_continue), .sleep_enter(sleep_enter), .sleep_release(sleep_release),
    .soft_reset(soft_reset), .cmd_reject(cmd_reject));
  sfcd_host sfcd_host_i (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .sio_in(sio_in),
    .sio_out(sio_out));
  task automatic give_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic take(input logic [39:0] o);
    if (exq.size() == 0) begin
      fails++;
      $display("BAD %0t unexpected %h", $time, o);
    end else `CHK(o, exq.pop_front())
  endtask
  task automatic np(input logic [6:0] p, input logic [1:0] s, input logic [23:0] a);
    exq.push_back({1'b0, 6'h0, p, s, a});
  endtask
  task automatic nrd(input logic [15:0] d);
    exq.push_back({1'b1, 23'h0, d});
  endtask
  task automatic hf(input logic [7:0] op, input bit qc, input logic [23:0] a, input int na,
      input bit qa, input int nd, input int nr);
    sfcd_host_i.frame(op, qc, a, na, qa, nd, nr);
  endtask
  task automatic settle;
    repeat (8) @(negedge sys_clk);
  endtask
  always @(negedge sys_clk) if (pv !== 7'h0)
    take({1'b0, 6'h0, pv, erase_start ? {erase_size, erase_addr} : 26'h0});
  always @(sfcd_host_i.rd_ev) take({1'b1, 23'h0, sfcd_host_i.rd_data});
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #900000;
    fails++;
    $display("BAD %0t timeout", $time);
    give_verdict;
  end
  initial begin
    rst_n = 1'b0;
    config_byte = 8'h0;
    status_byte = $random(seed);
    factory_byte = $random(seed);
    array_byte = $random(seed);
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    // defined codes only
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      #1 config_byte = {s[1:0], 6'h0};
      array_byte = $random(seed);
      ad = $random(seed);
      nrd({2{array_byte}});
      hf(8'h0b, 0, ad, 24, 0, dmy[s], 2);
    end
    nrd({8'h0, array_byte});
    hf(8'he7, 0, ad, 24, 1, 4, 1);
    hf(8'h06, 0, 0, 0, 0, 0, 0);
    settle;
    `CHK(write_permit_latch, 1'b1)
    np(7'h40, `SFCD_ERS_HALF, ad);
    hf(8'h52, 0, ad, 24, 0, 0, 0);
    settle;
    `CHK(write_permit_latch, 1'b0)
    np(7'h01, 2'h0, 24'h0);
    hf(8'h52, 0, ad, 24, 0, 0, 0);
    hf(8'h06, 0, 0, 0, 0, 0, 0);
    np(7'h01, 2'h0, 24'h0);
    hf(8'h52, 0, ad, 20, 0, 0, 0);
    for (int a = 0; a < 2; a++) begin
      nrd(a ? {PT, MK} : {MK, PT});
      hf(8'h90, 0, {16'h0, a[7:0]}, 24, 0, 0, 2);
    end
    nrd({8'h0, SG});
    np(7'h04, 2'h0, 24'h0);
    hf(8'hab, 0, 0, 0, 0, 24, 1);
    for (int i = 0; i < 5; i++) begin
      np(pls[i], 2'h0, 24'h0);
      hf(ops[i], 0, 0, 0, 0, 0, 0);
    end
    // arm then reset; an arm broken by another command is ignored
    hf(8'h66, 0, 0, 0, 0, 0, 0);
    np(7'h02, 2'h0, 24'h0);
    hf(8'h99, 0, 0, 0, 0, 0, 0);
    hf(8'h66, 0, 0, 0, 0, 0, 0);
    hf(8'h06, 0, 0, 0, 0, 0, 0);
    hf(8'h99, 0, 0, 0, 0, 0, 0);
    hf(8'h35, 0, 0, 0, 0, 0, 0);
    ad = $random(seed);
    nrd({2{array_byte}});
    hf(8'h0b, 1, ad, 24, 1, 10, 2);
    settle;
    `CHK(quad_mode, 1'b1)
    np(7'h01, 2'h0, 24'h0);
    hf(8'hbb, 1, ad, 24, 1, 0, 0);
    np(7'h01, 2'h0, 24'h0);
    hf(8'h35, 1, 0, 0, 1, 0, 0);
    nrd({8'h0, factory_byte});
    hf(8'h44, 1, 0, 0, 1, 0, 1);
    hf(8'h06, 1, 0, 0, 1, 0, 0);
    np(7'h40, `SFCD_ERS_HALF, ad);
    hf(8'h52, 1, ad, 24, 1, 0, 0);
    hf(8'hf5, 1, 0, 0, 1, 0, 0);
    np(7'h01, 2'h0, 24'h0);
    hf(8'hf5, 0, 0, 0, 0, 0, 0);
    settle;
    `CHK(quad_mode, 1'b0)
    for (int i = 0; i < 50 && exq.size() != 0; i++) @(posedge sys_clk);
    if (exq.size() != 0) begin
      fails++;
      $display("BAD %0t missing results", $time);
    end
    give_verdict;
  end
endmodule
